/* File: shared/lbdc_regs.svh */
`ifndef LBDC_REGS_SVH
`define LBDC_REGS_SVH

`define LBDC_ADDR_CTRL    8'h00
`define LBDC_ADDR_FADE    8'h04
`define LBDC_ADDR_BRIGHT  8'h08
`define LBDC_ADDR_FREQ    8'h0C
`define LBDC_ADDR_FILTER  8'h10
`define LBDC_ADDR_LEDEN   8'h14
`define LBDC_ADDR_STATUS  8'h18

`define LBDC_CTRL_SRC_LSB   0
`define LBDC_CTRL_LOG_BIT   2
`define LBDC_CTRL_MIXED_BIT 3
`define LBDC_CTRL_SWP_LSB   4
`define LBDC_FILT_HYST_LSB  0
`define LBDC_FILT_RC_LSB    2

`define LBDC_CTRL_RST    6'h00
`define LBDC_FADE_RST    8'h00
`define LBDC_BRIGHT_RST  12'h000
`define LBDC_FREQ_RST    3'h0
`define LBDC_FILTER_RST  4'h0
`define LBDC_LEDEN_RST   6'h3F

`define LBDC_CLK_KHZ        20000
`define LBDC_FADE_STEP_NS   50000
`define LBDC_FADE_STEP_CYC  ((`LBDC_FADE_STEP_NS * `LBDC_CLK_KHZ) / 1000000)
`define LBDC_RC_TICK_US     720
`define LBDC_RC_TICK_CYC    ((`LBDC_RC_TICK_US * `LBDC_CLK_KHZ) / 1000)
`define LBDC_OUT_FREQ_HZ    2500
`define LBDC_OUT_PERIOD_CYC ((`LBDC_CLK_KHZ * 1000) / `LBDC_OUT_FREQ_HZ)
`define LBDC_FULL_CODE      12'hFFF
`endif

/* File: shared/lbdc_pkg.sv */
package lbdc_pkg;
  typedef enum logic [1:0] {
    LBDC_SRC_PWM    = 2'b00,
    LBDC_SRC_REG    = 2'b01,
    LBDC_SRC_PROD   = 2'b10,
    LBDC_SRC_DIRECT = 2'b11
  } lbdc_src_t;

  typedef enum logic [1:0] {
    LBDC_SCH_ANALOG = 2'b00,
    LBDC_SCH_MIXED  = 2'b01,
    LBDC_SCH_DIRECT = 2'b11
  } lbdc_scheme_t;

  typedef enum logic [1:0] {
    LBDC_DIV_IDLE = 2'b00,
    LBDC_DIV_RUN  = 2'b01,
    LBDC_DIV_DONE = 2'b11
  } lbdc_div_t;
endpackage

/* File: verilog/lbdc_top.sv */
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "lbdc_regs.svh"
module lbdc_top #(
  parameter int RC_TICK_CYC    = `LBDC_RC_TICK_CYC,
  parameter int OUT_PERIOD_CYC = `LBDC_OUT_PERIOD_CYC
) (
  input  wire logic        pclk,                   // 20 MHz clock
  input  wire logic        presetn,                // Async reset, active low
  input  wire logic [7:0]  paddr,                  // APB address
  input  wire logic        psel,                   // APB select
  input  wire logic        penable,                // APB enable
  input  wire logic        pwrite,                 // APB write
  input  wire logic [31:0] pwdata,                 // APB write data
  output logic      [31:0] prdata,                 // APB read data
  output logic             pready,                 // APB ready
  output logic             pslverr,                // APB error on unmapped
  input  wire logic        register_interface_used, // Strap: registers in use
  input  wire logic        mode_pin_grounded,      // Scheme pin tied low
  input  wire logic        mode_pin_supply,        // Scheme pin tied high
  input  wire logic        pwm_in,                 // Brightness PWM input
  output logic      [5:0]  sink_on,                // Per-string sink enable
  output logic      [11:0] sink_level,             // Sink current level
  output var lbdc_pkg::lbdc_scheme_t strap_scheme  // Scheme caught at startup
);
  import lbdc_pkg::*;

  localparam int FADE_STEP_CYC = `LBDC_FADE_STEP_CYC;

  logic [5:0]  ctrl;
  logic [7:0]  fade_speed;
  logic [11:0] register_brightness_code;
  logic [2:0]  output_pwm_frequency_select;
  logic [3:0]  filter_cfg;
  logic [5:0]  string_en;
  logic        started;
  logic        regif;

  // Startup straps: caught on the first edge after release, then frozen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      started      <= 1'b0;
      regif        <= 1'b0;
      strap_scheme <= LBDC_SCH_ANALOG;
    end else if (!started) begin
      started <= 1'b1;
      regif   <= register_interface_used;
      if (mode_pin_grounded) begin
        strap_scheme <= LBDC_SCH_ANALOG;
      end else if (mode_pin_supply) begin
        strap_scheme <= LBDC_SCH_DIRECT;
      end else begin
        strap_scheme <= LBDC_SCH_MIXED;
      end
    end
  end

  // Effective settings; without registers the fixed pin-mode values apply
  lbdc_src_t   src;
  logic        log_map;
  logic        mixed;
  logic [1:0]  analog_to_pwm_switch_point;
  logic [7:0]  speed;
  logic [2:0]  fsel;
  logic [1:0]  smoothing_filter_coefficient;
  logic [1:0]  input_duty_hysteresis_threshold;
  logic [5:0]  en;
  always_comb begin
    if (regif) begin
      src     = lbdc_src_t'(ctrl[`LBDC_CTRL_SRC_LSB +: 2]);
      log_map = ctrl[`LBDC_CTRL_LOG_BIT];
      mixed   = ctrl[`LBDC_CTRL_MIXED_BIT];
      analog_to_pwm_switch_point = ctrl[`LBDC_CTRL_SWP_LSB +: 2];
      speed   = fade_speed;
      fsel    = output_pwm_frequency_select;
      smoothing_filter_coefficient    = filter_cfg[`LBDC_FILT_RC_LSB +: 2];
      input_duty_hysteresis_threshold = filter_cfg[`LBDC_FILT_HYST_LSB +: 2];
      en      = string_en;
    end else begin
      src     = (strap_scheme == LBDC_SCH_DIRECT) ? LBDC_SRC_DIRECT : LBDC_SRC_PWM;
      log_map = 1'b0;
      mixed   = (strap_scheme == LBDC_SCH_MIXED);
      analog_to_pwm_switch_point = 2'b01;
      speed   = 8'h00;
      fsel    = 3'h0;
      smoothing_filter_coefficient    = 2'b00;
      input_duty_hysteresis_threshold = 2'b00;
      en      = 6'h3F;
    end
  end

  // APB slave: zero wait states, read data captured in the setup cycle
  logic        setup;
  logic        wr;
  logic        mapped;
  logic [11:0] duty_f;
  logic [11:0] applied;
  logic        trend_up;
  assign setup   = psel & ~penable;
  assign wr      = psel & penable & pwrite;
  assign pready  = 1'b1;
  assign mapped  = (paddr <= `LBDC_ADDR_STATUS) && (paddr[1:0] == 2'b00);
  assign pslverr = psel & penable & ~mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl                        <= `LBDC_CTRL_RST;
      fade_speed                  <= `LBDC_FADE_RST;
      register_brightness_code    <= `LBDC_BRIGHT_RST;
      output_pwm_frequency_select <= `LBDC_FREQ_RST;
      filter_cfg                  <= `LBDC_FILTER_RST;
      string_en                   <= `LBDC_LEDEN_RST;
    end else if (wr) begin
      if (paddr == `LBDC_ADDR_CTRL) begin
        ctrl <= pwdata[5:0];
      end else if (paddr == `LBDC_ADDR_FADE) begin
        fade_speed <= pwdata[7:0];
      end else if (paddr == `LBDC_ADDR_BRIGHT) begin
        register_brightness_code <= pwdata[11:0];
      end else if (paddr == `LBDC_ADDR_FREQ) begin
        output_pwm_frequency_select <= pwdata[2:0];
      end else if (paddr == `LBDC_ADDR_FILTER) begin
        filter_cfg <= pwdata[3:0];
      end else if (paddr == `LBDC_ADDR_LEDEN) begin
        string_en <= pwdata[5:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      if (paddr == `LBDC_ADDR_CTRL) begin
        prdata <= {26'h000_0000, ctrl};
      end else if (paddr == `LBDC_ADDR_FADE) begin
        prdata <= {24'h00_0000, fade_speed};
      end else if (paddr == `LBDC_ADDR_BRIGHT) begin
        prdata <= {20'h0_0000, register_brightness_code};
      end else if (paddr == `LBDC_ADDR_FREQ) begin
        prdata <= {29'h0000_0000, output_pwm_frequency_select};
      end else if (paddr == `LBDC_ADDR_FILTER) begin
        prdata <= {28'h000_0000, filter_cfg};
      end else if (paddr == `LBDC_ADDR_LEDEN) begin
        prdata <= {26'h000_0000, string_en};
      end else if (paddr == `LBDC_ADDR_STATUS) begin
        prdata <= {6'h00, regif, trend_up, applied, duty_f};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Input duty measurement at half the clock rate, near the 10 MHz grid
  logic        meas_tick;
  logic        pwm_q;
  logic        pwm_rise;
  logic [15:0] on_cnt;
  logic [15:0] per_cnt;
  assign pwm_rise = pwm_in & ~pwm_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_tick <= 1'b0;
      pwm_q     <= 1'b0;
      on_cnt    <= 16'h0000;
      per_cnt   <= 16'h0000;
    end else begin
      meas_tick <= ~meas_tick;
      pwm_q     <= pwm_in;
      if (pwm_rise) begin
        on_cnt  <= 16'h0000;
        per_cnt <= 16'h0000;
      end else if (meas_tick) begin
        if (per_cnt != 16'hFFFF) begin
          per_cnt <= per_cnt + 16'h0001;
        end
        if (pwm_in && on_cnt != 16'hFFFF) begin
          on_cnt <= on_cnt + 16'h0001;
        end
      end
    end
  end

  // Serial divider: duty = on * 4096 / period, saturating at full code
  lbdc_div_t   div_state;
  logic [15:0] div_rem;
  logic [15:0] div_per;
  logic [11:0] div_q;
  logic [3:0]  div_bits;
  logic [16:0] rem2;
  assign rem2 = {div_rem, 1'b0};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_state <= LBDC_DIV_IDLE;
      div_rem   <= 16'h0000;
      div_per   <= 16'h0000;
      div_q     <= 12'h000;
      div_bits  <= 4'h0;
    end else begin
      case (div_state)
        LBDC_DIV_IDLE: begin
          if (pwm_rise && src != LBDC_SRC_DIRECT && per_cnt != 16'h0000) begin
            div_rem   <= (on_cnt > per_cnt) ? per_cnt : on_cnt;
            div_per   <= per_cnt;
            div_q     <= 12'h000;
            div_bits  <= 4'hC;
            div_state <= LBDC_DIV_RUN;
          end
        end
        LBDC_DIV_RUN: begin
          if (rem2 >= {1'b0, div_per}) begin
            div_rem <= 16'(rem2 - {1'b0, div_per});
            div_q   <= {div_q[10:0], 1'b1};
          end else begin
            div_rem <= rem2[15:0];
            div_q   <= {div_q[10:0], 1'b0};
          end
          div_bits <= div_bits - 4'h1;
          if (div_bits == 4'h1) begin
            div_state <= LBDC_DIV_DONE;
          end
        end
        default: begin
          div_state <= LBDC_DIV_IDLE;
        end
      endcase
    end
  end

  // Reversal hysteresis on the sampled duty
  logic [11:0] hyst_thr;
  assign hyst_thr = 12'h001 << input_duty_hysteresis_threshold;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_f   <= 12'h000;
      trend_up <= 1'b1;
    end else if (div_state == LBDC_DIV_DONE) begin
      if (input_duty_hysteresis_threshold == 2'b00) begin
        duty_f <= div_q;
      end else if (div_q > duty_f && (trend_up || div_q - duty_f >= hyst_thr)) begin
        duty_f   <= div_q;
        trend_up <= 1'b1;
      end else if (div_q < duty_f && (!trend_up || duty_f - div_q >= hyst_thr)) begin
        duty_f   <= div_q;
        trend_up <= 1'b0;
      end
    end
  end

  // Log curve: 10-bit index as 4-bit exponent and 6-bit mantissa
  function automatic logic [11:0] lbdc_map(input logic [11:0] code, input logic lg);
    logic [21:0] v;
    v = {15'h0000, 1'b1, code[7:2]} << code[11:8];
    if (!lg) begin
      lbdc_map = code;
    end else if (code[11:2] == 10'h000) begin
      lbdc_map = 12'h000;
    end else begin
      lbdc_map = v[21:10];
    end
  endfunction

  logic [11:0] pwm_code;
  logic [11:0] reg_code;
  logic [23:0] prod;
  logic [11:0] target;
  assign pwm_code = lbdc_map(duty_f, log_map);
  assign reg_code = lbdc_map(register_brightness_code, log_map);
  assign prod     = reg_code * pwm_code;
  always_comb begin
    case (src)
      LBDC_SRC_REG:  target = reg_code;
      LBDC_SRC_PROD: target = prod[23:12];
      default:       target = pwm_code;
    endcase
  end

  // Fade: one code per speed x 50 us
  logic [15:0] fade_base;
  logic [7:0]  fade_n;
  logic [11:0] fade_code;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fade_base <= 16'h0000;
      fade_n    <= 8'h00;
      fade_code <= 12'h000;
    end else if (speed == 8'h00) begin
      fade_base <= 16'h0000;
      fade_n    <= 8'h00;
      fade_code <= target;
    end else if (fade_base == 16'(FADE_STEP_CYC - 1)) begin
      fade_base <= 16'h0000;
      if (fade_n + 8'h01 >= speed) begin
        fade_n <= 8'h00;
        if (fade_code < target) begin
          fade_code <= fade_code + 12'h001;
        end else if (fade_code > target) begin
          fade_code <= fade_code - 12'h001;
        end
      end else begin
        fade_n <= fade_n + 8'h01;
      end
    end else begin
      fade_base <= fade_base + 16'h0001;
    end
  end

  // First-order smoothing on its own tick, unrelated to the output rate
  logic [15:0]        rc_tick_cnt;
  logic [21:0]        rc_y;
  logic signed [22:0] rc_diff;
  logic signed [22:0] rc_step;
  assign rc_diff = $signed({1'b0, fade_code, 10'h000}) - $signed({1'b0, rc_y});
  assign rc_step = rc_diff >>> (4'hB - {2'b00, smoothing_filter_coefficient});
  assign applied = rc_y[21:10];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_tick_cnt <= 16'h0000;
      rc_y        <= 22'h00_0000;
    end else if (smoothing_filter_coefficient == 2'b00) begin
      rc_tick_cnt <= 16'h0000;
      rc_y        <= {fade_code, 10'h000};
    end else if (rc_tick_cnt == 16'(RC_TICK_CYC - 1)) begin
      rc_tick_cnt <= 16'h0000;
      // A truncated step stalls one code short of the target, so snap on a zero step
      rc_y        <= (rc_step == 23'sh0) ? {fade_code, 10'h000} : rc_y + rc_step[21:0];
    end else begin
      rc_tick_cnt <= rc_tick_cnt + 16'h0001;
    end
  end

  // Output dimming cycle, own timebase regardless of input rate
  logic [13:0] per_sel;
  logic [13:0] out_cnt;
  logic [13:0] lat_per;
  logic [11:0] lat_code;
  logic [5:0]  lat_en;
  logic        lat_pwm;
  logic [13:0] lat_duty;
  logic [3:0]  sp_shift;
  logic [11:0] sp_level;
  logic [25:0] duty_prod;
  logic [2:0]  n_en;
  logic [13:0] phase_step;
  always_comb begin
    case (fsel)
      3'h0:    per_sel = 14'(OUT_PERIOD_CYC);
      3'h1:    per_sel = 14'(OUT_PERIOD_CYC >> 1);
      3'h2:    per_sel = 14'(OUT_PERIOD_CYC >> 2);
      3'h3:    per_sel = 14'(OUT_PERIOD_CYC >> 3);
      default: per_sel = 14'(OUT_PERIOD_CYC >> 4);
    endcase
    sp_shift = 4'h9 + {2'b00, analog_to_pwm_switch_point};
    sp_level = (analog_to_pwm_switch_point == 2'b11) ? `LBDC_FULL_CODE : 12'h001 << sp_shift;
    duty_prod = applied * per_sel;
  end

  function automatic logic [2:0] lbdc_ones(input logic [5:0] v);
    lbdc_ones = 3'h0;
    for (int k = 0; k < 6; k++) begin
      lbdc_ones = lbdc_ones + {2'b00, v[k]};
    end
  endfunction

  assign n_en = lbdc_ones(lat_en);
  always_comb begin
    case (n_en)
      3'h2:    phase_step = lat_per >> 1;
      3'h3:    phase_step = lat_per / 14'd3;
      3'h4:    phase_step = lat_per >> 2;
      3'h5:    phase_step = lat_per / 14'd5;
      3'h6:    phase_step = lat_per / 14'd6;
      default: phase_step = lat_per;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_cnt    <= 14'h0000;
      lat_per    <= 14'(OUT_PERIOD_CYC);
      lat_code   <= 12'h000;
      lat_en     <= 6'h00;
      lat_pwm    <= 1'b0;
      lat_duty   <= 14'h0000;
      sink_level <= 12'h000;
    end else if (out_cnt == 14'h0000) begin
      out_cnt    <= (per_sel > 14'h0001) ? 14'h0001 : 14'h0000;
      lat_per    <= per_sel;
      lat_code   <= applied;
      lat_en     <= en;
      lat_pwm    <= mixed && applied < sp_level;
      lat_duty   <= 14'(duty_prod >> sp_shift);
      if (src == LBDC_SRC_DIRECT) begin
        sink_level <= `LBDC_FULL_CODE;
      end else if (mixed && applied < sp_level) begin
        sink_level <= sp_level;
      end else begin
        sink_level <= applied;
      end
    end else begin
      out_cnt <= (out_cnt + 14'h0001 >= lat_per) ? 14'h0000 : out_cnt + 14'h0001;
    end
  end

  // Phase lags the counter by one so every slot sees its own cycle's latched values
  logic [13:0] out_ph;
  assign out_ph = (out_cnt == 14'h0000) ? lat_per - 14'h0001 : out_cnt - 14'h0001;

  // Per-string phase: rank among enabled strings times the phase step
  for (genvar i = 0; i < 6; i++) begin : g_string
    logic [2:0]  rank;
    logic [16:0] offs;
    logic [13:0] pos;
    assign rank = lbdc_ones(lat_en & 6'((1 << i) - 1));
    assign offs = phase_step * rank;
    assign pos  = (out_ph >= offs[13:0]) ? out_ph - offs[13:0]
                                         : 14'(out_ph + lat_per - offs[13:0]);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sink_on[i] <= 1'b0;
      end else if (src == LBDC_SRC_DIRECT) begin
        sink_on[i] <= en[i] & pwm_in;
      end else if (lat_pwm) begin
        sink_on[i] <= lat_en[i] & (pos < lat_duty);
      end else begin
        sink_on[i] <= lat_en[i] & (lat_code != 12'h000);
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/lbdc_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module lbdc_top_assertions
  import lbdc_pkg::*;
#(
  parameter int OUT_PERIOD_CYC = 8000
) (
  input wire logic         pclk, // Clock
  input wire logic         presetn, // Reset
  input wire logic         psel, // Select
  input wire logic         penable, // Enable
  input wire logic         pslverr, // Error
  input wire logic [31:0]  prdata, // Read data
  input wire logic         register_interface_used, // Strap
  input wire logic         mode_pin_grounded, // Pin low
  input wire logic         mode_pin_supply, // Pin high
  input wire logic         pwm_in, // PWM in
  input wire logic [5:0]   sink_on, // Strings
  input wire logic [11:0]  sink_level, // Level
  input wire lbdc_scheme_t strap_scheme // Scheme
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic        pin_mode;
  logic        lvl_seen;
  logic        rise_seen;
  logic        on0_q;
  logic [11:0] lvl_q;
  logic [31:0] lvl_gap;
  logic [31:0] rise_gap;
  assign pin_mode = !register_interface_used;
  // Gaps since the last level change and the last string 0 rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_q     <= 12'h000;
      on0_q     <= 1'b0;
      lvl_gap   <= 32'h0;
      rise_gap  <= 32'h0;
      lvl_seen  <= 1'b0;
      rise_seen <= 1'b0;
    end else begin
      lvl_q    <= sink_level;
      on0_q    <= sink_on[0];
      lvl_gap  <= (sink_level != lvl_q) ? 32'h0 : lvl_gap + 32'h1;
      rise_gap <= (sink_on[0] && !on0_q) ? 32'h0 : rise_gap + 32'h1;
      lvl_seen <= lvl_seen || (sink_level != lvl_q);
      rise_seen <= rise_seen || (sink_on[0] && !on0_q);
    end
  end
  property p_strap_capture;
    pin_mode && $past(presetn) && !$past(presetn, 2) |-> strap_scheme ==
      ($past(mode_pin_grounded) ? LBDC_SCH_ANALOG :
       $past(mode_pin_supply) ? LBDC_SCH_DIRECT : LBDC_SCH_MIXED);
  endproperty
  a_strap_capture: assert property (p_strap_capture)
    else $error("scheme not taken from pins");
  property p_strap_hold;
    $past(presetn, 2) |-> $stable(strap_scheme);
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("scheme moved after startup");
  property p_direct;
    pin_mode && strap_scheme == LBDC_SCH_DIRECT && $past(strap_scheme) == LBDC_SCH_DIRECT
      |-> sink_on == {6{$past(pwm_in)}};
  endproperty
  a_direct: assert property (p_direct)
    else $error("strings not following input");
  property p_dc_level;
    pin_mode && strap_scheme == LBDC_SCH_ANALOG && $stable(sink_level)
      |-> sink_on == {6{sink_level != 12'h000}};
  endproperty
  a_dc_level: assert property (p_dc_level)
    else $error("strings wrong in DC mode");
  property p_lvl_cycle;
    pin_mode && lvl_seen && sink_level != lvl_q |-> ((lvl_gap + 32'h1) % OUT_PERIOD_CYC) == 0;
  endproperty
  a_lvl_cycle: assert property (p_lvl_cycle)
    else $error("level changed mid cycle");
  property p_out_rate;
    pin_mode && rise_seen && strap_scheme != LBDC_SCH_DIRECT && sink_on[0] && !on0_q
      |-> ((rise_gap + 32'h1) % OUT_PERIOD_CYC) == 0;
  endproperty
  a_out_rate: assert property (p_out_rate)
    else $error("output rate wrong");
  property p_err_read;
    psel && penable && pslverr |-> prdata == 32'h0;
  endproperty
  a_err_read: assert property (p_err_read)
    else $error("refused read not zero");
  property p_err_phase;
    pslverr |-> psel && penable;
  endproperty
  a_err_phase: assert property (p_err_phase)
    else $error("error outside access");
endmodule
bind lbdc_top lbdc_top_assertions #(.OUT_PERIOD_CYC(OUT_PERIOD_CYC)) i_lbdc_top_assertions (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pslverr(pslverr),
  .prdata(prdata), .register_interface_used(register_interface_used),
  .mode_pin_grounded(mode_pin_grounded), .mode_pin_supply(mode_pin_supply),
  .pwm_in(pwm_in), .sink_on(sink_on), .sink_level(sink_level), .strap_scheme(strap_scheme)
);
`default_nettype wire

/* File: verification/lbdc_pwm_host.sv */
`timescale 1ns/1ps
`default_nettype none
module lbdc_pwm_host (
  input  wire logic        pclk, // Clock
  input  wire logic        presetn, // Restarts the wave
  input  wire logic [15:0] high_cyc, // High time in clocks
  input  wire logic [15:0] period_cyc, // Period in clocks
  output logic             pwm_in // Brightness input
);
  logic [15:0] cnt;
  logic [15:0] hi_l;
  logic [15:0] per_l;
  // Settings land at a period boundary so every measured period is whole
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt   <= 16'h0000;
      hi_l  <= 16'h0000;
      per_l <= 16'h0800;
    end else if (cnt >= per_l - 16'h0001) begin
      cnt   <= 16'h0000;
      per_l <= (period_cyc < 16'h01F4) ? 16'h01F4 : period_cyc;
      hi_l  <= (high_cyc < 16'h0004) ? 16'h0004 : high_cyc;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
  assign pwm_in = presetn && (cnt < hi_l);
endmodule
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lbdc_regs.svh"
module tb;
  import lbdc_pkg::*;
  localparam int OUT_CYC = 160;
  logic         pclk;
  logic         presetn;
  logic [7:0]   paddr;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [31:0]  pwdata;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         reg_used;
  logic         pin_gnd;
  logic         pin_sup;
  logic         pwm_in;
  logic [5:0]   sink_on;
  logic [11:0]  sink_level;
  lbdc_scheme_t strap_scheme;
  logic [15:0]  high_cyc;
  logic [15:0]  period_cyc;
  logic [31:0]  rd;
  logic         err_q;
  int           err_total;
  int           checks;
  lbdc_top #(.RC_TICK_CYC(16), .OUT_PERIOD_CYC(OUT_CYC)) i_lbdc_top (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .register_interface_used(reg_used), .mode_pin_grounded(pin_gnd),
    .mode_pin_supply(pin_sup), .pwm_in(pwm_in), .sink_on(sink_on),
    .sink_level(sink_level), .strap_scheme(strap_scheme));
  lbdc_pwm_host i_lbdc_pwm_host (.pclk(pclk), .presetn(presetn), .high_cyc(high_cyc),
    .period_cyc(period_cyc), .pwm_in(pwm_in));
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic do_reset(input logic ru, input logic g, input logic s);
    presetn <= 1'b0;
    reg_used <= ru;
    pin_gnd <= g;
    pin_sup <= s;
    cyc(3);
    presetn <= 1'b1;
    cyc(3);
  endtask
  task automatic t_regs();
    logic [31:0] exp [6];
    exp = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h3F};
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, exp[i]);
    end
    apb(1'b0, `LBDC_ADDR_STATUS, 32'h0);
    chk(rd[25], 1'b1);
    apb(1'b0, 8'h1C, 32'h0);
    chk(err_q, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, `LBDC_ADDR_FREQ, 32'hFFFFFFFF);
    apb(1'b0, `LBDC_ADDR_FREQ, 32'h0);
    chk(rd, 32'h7);
  endtask
  task automatic t_map();
    logic [11:0] code [3];
    logic [11:0] exp [3];
    code = '{12'h800, 12'hFFF, 12'h003};
    exp = '{12'h010, 12'hFE0, 12'h000};
    apb(1'b1, `LBDC_ADDR_BRIGHT, 32'h800);
    apb(1'b1, `LBDC_ADDR_CTRL, 32'h1);
    cyc(2 * OUT_CYC);
    chk(sink_level, 12'h800);
    apb(1'b1, `LBDC_ADDR_LEDEN, 32'h05);
    cyc(2 * OUT_CYC);
    chk(sink_on, 6'h05);
    apb(1'b1, `LBDC_ADDR_LEDEN, 32'h3F);
    apb(1'b1, `LBDC_ADDR_CTRL, 32'h5);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `LBDC_ADDR_BRIGHT, {20'h0, code[i]});
      cyc(2 * OUT_CYC);
      apb(1'b0, `LBDC_ADDR_STATUS, 32'h0);
      chk(rd[23:12], exp[i]);
    end
  endtask
  // Three input periods: one to land the setting, two rises to measure it
  task automatic t_pwm_src();
    apb(1'b1, `LBDC_ADDR_CTRL, 32'h0);
    cyc(6144);
    apb(1'b0, `LBDC_ADDR_STATUS, 32'h0);
    chk(rd[11:0], 12'h400);
    chk(rd[23:12], 12'h400);
    apb(1'b1, `LBDC_ADDR_BRIGHT, 32'h800);
    apb(1'b1, `LBDC_ADDR_CTRL, 32'h2);
    cyc(2 * OUT_CYC);
    apb(1'b0, `LBDC_ADDR_STATUS, 32'h0);
    chk(rd[23:12], 12'h200);
    apb(1'b1, `LBDC_ADDR_CTRL, 32'h3);
    cyc(2 * OUT_CYC);
    chk(sink_level, 12'hFFF);
  endtask
  task automatic t_fade();
    apb(1'b1, `LBDC_ADDR_CTRL, 32'h1);
    apb(1'b1, `LBDC_ADDR_BRIGHT, 32'h200);
    cyc(2 * OUT_CYC);
    apb(1'b1, `LBDC_ADDR_FADE, 32'h1);
    apb(1'b1, `LBDC_ADDR_BRIGHT, 32'h210);
    cyc(5500);
    apb(1'b0, `LBDC_ADDR_STATUS, 32'h0);
    chk(rd[23:12] > 12'h204 && rd[23:12] < 12'h207, 1'b1);
    cyc(11000);
    apb(1'b0, `LBDC_ADDR_STATUS, 32'h0);
    chk(rd[23:12], 12'h210);
    apb(1'b1, `LBDC_ADDR_FADE, 32'h0);
  endtask
  // Coefficient changed only with strings off; a few ticks move part way only
  task automatic t_rc();
    apb(1'b1, `LBDC_ADDR_LEDEN, 32'h0);
    apb(1'b1, `LBDC_ADDR_FILTER, 32'hC);
    apb(1'b1, `LBDC_ADDR_LEDEN, 32'h3F);
    apb(1'b1, `LBDC_ADDR_BRIGHT, 32'hA00);
    cyc(64);
    apb(1'b0, `LBDC_ADDR_STATUS, 32'h0);
    chk(rd[23:12] > 12'h210, 1'b1);
    chk(rd[23:12] < 12'h300, 1'b1);
    apb(1'b1, `LBDC_ADDR_LEDEN, 32'h0);
    apb(1'b1, `LBDC_ADDR_FILTER, 32'h0);
    apb(1'b1, `LBDC_ADDR_LEDEN, 32'h3F);
  endtask
  task automatic t_hyst();
    logic [15:0] hi [5];
    logic [11:0] exp [5];
    hi = '{16'h0400, 16'h03FE, 16'h03FC, 16'h03FE, 16'h03FA};
    exp = '{12'h800, 12'h800, 12'h7F8, 12'h7F8, 12'h7F4};
    apb(1'b1, `LBDC_ADDR_FILTER, 32'h3);
    apb(1'b1, `LBDC_ADDR_CTRL, 32'h0);
    for (int i = 0; i < 5; i++) begin
      high_cyc <= hi[i];
      cyc(6144);
      apb(1'b0, `LBDC_ADDR_STATUS, 32'h0);
      chk(rd[11:0], exp[i]);
    end
  endtask
  task automatic t_pins();
    logic [1:0]   pins [3];
    lbdc_scheme_t exp [3];
    logic [11:0]  lvl [3];
    pins = '{2'b10, 2'b00, 2'b01};
    lvl = '{12'h200, 12'h400, 12'hFFF};
    exp = '{LBDC_SCH_ANALOG, LBDC_SCH_MIXED, LBDC_SCH_DIRECT};
    for (int i = 0; i < 3; i++) begin
      high_cyc <= 16'h0100;
      do_reset(1'b0, pins[i][1], pins[i][0]);
      pin_gnd <= ~pins[i][1];
      pin_sup <= ~pins[i][0];
      cyc(6144);
      chk(strap_scheme, exp[i]);
      chk(sink_level, lvl[i]);
      if (i == 0) begin
        high_cyc <= 16'h0200;
        cyc(6144);
        chk(sink_level, 12'h400);
      end
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d errors=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    reg_used = 1'b1;
    pin_gnd = 1'b0;
    pin_sup = 1'b0;
    high_cyc = 16'h0200;
    period_cyc = 16'h0800;
    err_total = 0;
    checks = 0;
    @(posedge pclk);
    do_reset(1'b1, 1'b0, 1'b0);
    t_regs();
    t_map();
    t_pwm_src();
    t_fade();
    t_rc();
    t_hyst();
    t_pins();
    finish_test();
  end
  initial begin
    #4_700_000;
    err_total++;
    finish_test();
  end
endmodule
`default_nettype wire
